/* logic/crs_top.sv */
// CRT cursor, screen start and vertical sync registers with their display logic.
// Assumes scanline, row-scan and fetch address come from the CRT counters,
// and that the extension registers hold the upper start address bits.
`timescale 1ns/1ps

module crs_top
  import crs_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int VLINE_W = 10
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  // Host I/O port
  input  wire logic [15:0]        io_addr_i,
  input  wire logic               io_wr_i,
  input  wire logic               io_rd_i,
  input  wire logic [7:0]         io_wdata_i,
  output logic      [7:0]         io_rdata_o,
  output logic                    io_rdata_oe_o,
  input  wire logic               mono_mode_i,
  // Extension bits held elsewhere
  input  wire logic [2:0]         start_addr_ext_i,
  input  wire logic               start_addr_top_ext_i,
  input  wire logic               refresh_one_i,
  // CRT counters
  input  wire logic               char_clk_en_i,
  input  wire logic               line_start_i,
  input  wire logic [VLINE_W-1:0] scanline_i,
  input  wire logic [4:0]         row_scan_i,
  input  wire logic [ADDR_W-1:0]  fetch_addr_i,
  // Timing results
  output logic [19:0]             start_addr_o,
  output logic [4:0]              cell_height_o,
  output logic                    cursor_o,
  output logic                    vsync_o,
  output logic [2:0]              refresh_cycles_o,
  output logic                    timing_protect_o,
  output logic                    irq_pending_o,
  output logic                    irq_out_n_o
);

  // ==========================================================================
  // Elaboration checks
  initial begin
    if (ADDR_W != 16) begin
      $error("crs_top: ADDR_W must be 16 to match the cursor location.");
    end
    if (VLINE_W != 10) begin
      $error("crs_top: VLINE_W must be 10 to match the sync start field.");
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [4:0] clamp_end(input logic [4:0] end_v,
                                           input logic [4:0] height);
    if (end_v > height) begin
      return height;
    end
    return end_v;
  endfunction

  function automatic logic port_hit(input logic [15:0] addr,
                                    input logic        mono,
                                    input logic [15:0] ofs);
    logic [15:0] base;
    base = mono ? CRS_MONO_BASE : CRS_COLOR_BASE;
    return addr == (base + ofs);
  endfunction

  // ==========================================================================
  // Register storage
  logic [7:0] index_reg;
  logic [7:0] overflow_reg;
  logic [7:0] cell_height_reg;
  logic [7:0] cursor_start_reg;
  logic [7:0] cursor_end_reg;
  logic [7:0] start_addr_hi_reg;
  logic [7:0] start_addr_lo_reg;
  logic [7:0] cursor_loc_hi_reg;
  logic [7:0] cursor_loc_lo_reg;
  logic [7:0] vsync_start_reg;
  logic [7:0] vsync_end_reg;

  logic index_sel;
  logic data_sel;
  logic data_wr;
  logic protect;

  assign index_sel = port_hit(io_addr_i, mono_mode_i, CRS_INDEX_OFS);
  assign data_sel  = port_hit(io_addr_i, mono_mode_i, CRS_DATA_OFS);
  assign data_wr   = io_wr_i && data_sel;
  assign protect   = vsync_end_reg[CRS_VE_PROTECT];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      index_reg <= CRS_REG_RESET;
    end else if (io_wr_i && index_sel) begin
      index_reg <= io_wdata_i;
    end
  end

  // The overflow register is in the protected range, but its line compare bit is not.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow_reg <= CRS_REG_RESET;
    end else if (data_wr && index_reg == CRS_IDX_OVERFLOW) begin
      if (protect) begin
        overflow_reg[CRS_OVF_LC8] <= io_wdata_i[CRS_OVF_LC8];
      end else begin
        overflow_reg <= io_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cell_height_reg   <= CRS_REG_RESET;
      cursor_start_reg  <= CRS_REG_RESET;
      cursor_end_reg    <= CRS_REG_RESET;
      start_addr_hi_reg <= CRS_REG_RESET;
      start_addr_lo_reg <= CRS_REG_RESET;
      cursor_loc_hi_reg <= CRS_REG_RESET;
      cursor_loc_lo_reg <= CRS_REG_RESET;
      vsync_start_reg   <= CRS_REG_RESET;
      vsync_end_reg     <= CRS_REG_RESET;
    end else if (data_wr) begin
      case (index_reg)
        CRS_IDX_CELL: begin
          cell_height_reg <= io_wdata_i;
        end
        CRS_IDX_CUR_START: begin
          cursor_start_reg <= io_wdata_i & CRS_CUR_START_MASK;
        end
        CRS_IDX_CUR_END: begin
          cursor_end_reg <= io_wdata_i & CRS_CUR_END_MASK;
        end
        CRS_IDX_START_HI: begin
          start_addr_hi_reg <= io_wdata_i;
        end
        CRS_IDX_START_LO: begin
          start_addr_lo_reg <= io_wdata_i;
        end
        CRS_IDX_CUR_HI: begin
          cursor_loc_hi_reg <= io_wdata_i;
        end
        CRS_IDX_CUR_LO: begin
          cursor_loc_lo_reg <= io_wdata_i;
        end
        CRS_IDX_VS_START: begin
          vsync_start_reg <= io_wdata_i;
        end
        CRS_IDX_VS_END: begin
          vsync_end_reg <= io_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Read port
  logic [7:0] read_mux;
  logic       read_hit;

  always_comb begin
    read_mux = 8'h00;
    read_hit = 1'b1;
    case (index_reg)
      CRS_IDX_OVERFLOW:  read_mux = overflow_reg;
      CRS_IDX_CELL:      read_mux = cell_height_reg;
      CRS_IDX_CUR_START: read_mux = cursor_start_reg;
      CRS_IDX_CUR_END:   read_mux = cursor_end_reg;
      CRS_IDX_START_HI:  read_mux = start_addr_hi_reg;
      CRS_IDX_START_LO:  read_mux = start_addr_lo_reg;
      CRS_IDX_CUR_HI:    read_mux = cursor_loc_hi_reg;
      CRS_IDX_CUR_LO:    read_mux = cursor_loc_lo_reg;
      CRS_IDX_VS_START:  read_mux = vsync_start_reg;
      CRS_IDX_VS_END:    read_mux = vsync_end_reg;
      default:           read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_rdata_o    <= 8'h00;
      io_rdata_oe_o <= 1'b0;
    end else if (io_rd_i && index_sel) begin
      io_rdata_o    <= index_reg;
      io_rdata_oe_o <= 1'b1;
    end else if (io_rd_i && data_sel && read_hit) begin
      io_rdata_o    <= read_mux;
      io_rdata_oe_o <= 1'b1;
    end else begin
      io_rdata_oe_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Screen start and control outputs
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_addr_o     <= 20'h00000;
      cell_height_o    <= 5'h00;
      refresh_cycles_o <= CRS_REFRESH_LO;
      timing_protect_o <= 1'b0;
    end else begin
      start_addr_o <= {start_addr_top_ext_i, start_addr_ext_i,
                       start_addr_hi_reg, start_addr_lo_reg};
      cell_height_o <= cell_height_reg[4:0];
      timing_protect_o <= protect;
      if (refresh_one_i) begin
        refresh_cycles_o <= CRS_REFRESH_ONE;
      end else if (vsync_end_reg[CRS_VE_REFRESH]) begin
        refresh_cycles_o <= CRS_REFRESH_HI;
      end else begin
        refresh_cycles_o <= CRS_REFRESH_LO;
      end
    end
  end

  // ==========================================================================
  // Text cursor
  logic [15:0] cursor_loc;
  logic [4:0]  cursor_last;
  logic        addr_match;
  logic        skewed_match;
  logic        row_in_cursor;

  assign cursor_loc  = {cursor_loc_hi_reg, cursor_loc_lo_reg};
  // The cell height field is height minus one, i.e. the last row index.
  assign cursor_last = clamp_end(cursor_end_reg[4:0], cell_height_reg[4:0]);
  // Compared with the raw fetch address, so moving the start does not move the cursor.
  assign addr_match  = fetch_addr_i == cursor_loc;
  assign row_in_cursor = !cursor_start_reg[CRS_CS_DISABLE]
                         && row_scan_i >= cursor_start_reg[4:0]
                         && row_scan_i <= cursor_last;

  crs_cursor_skew #(
    .DEPTH (CRS_SKEW_MAX)
  ) u_skew (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .step_i    (char_clk_en_i),
    .skew_i    (cursor_end_reg[6:5]),
    .match_i   (addr_match),
    .match_o   (skewed_match)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cursor_o <= 1'b0;
    end else if (char_clk_en_i) begin
      cursor_o <= skewed_match && row_in_cursor;
    end
  end

  // ==========================================================================
  // Vertical sync
  logic [9:0] vsync_start;
  logic       sync_begin;
  logic       sync_finish;

  assign vsync_start = {overflow_reg[CRS_OVF_VS9], overflow_reg[CRS_OVF_VS8],
                        vsync_start_reg};
  assign sync_begin  = line_start_i && scanline_i == vsync_start;
  assign sync_finish = line_start_i && scanline_i[3:0] == vsync_end_reg[3:0];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vsync_o <= 1'b0;
    end else if (sync_begin) begin
      vsync_o <= 1'b1;
    end else if (sync_finish) begin
      vsync_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Vertical interrupt
  logic irq_armed;
  logic irq_enabled;
  logic irq_event;

  assign irq_armed   = vsync_end_reg[CRS_VE_CLEAR];
  assign irq_enabled = !vsync_end_reg[CRS_VE_DISABLE];
  assign irq_event   = sync_begin && !vsync_o;

  // Clear is a level: while the clear bit is low no event can set the flag.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_pending_o <= 1'b0;
    end else if (!irq_armed) begin
      irq_pending_o <= 1'b0;
    end else if (irq_event && irq_enabled) begin
      irq_pending_o <= 1'b1;
    end
  end

  assign irq_out_n_o = !(irq_pending_o && irq_enabled && irq_armed);

endmodule // crs_top

/* logic/crs_pkg.sv */
// Constants for the CRT cursor, start address and vertical sync register block.
// Assumes an indexed I/O port pair whose base moves between colour and mono ranges.
//
// Behaviour
// - Cursor end clamps to the cell height.
// - Skew delays cursor by 0-3 character clocks.
// - Start address assembles bits 19:0 from four sources.
// - Cursor location is sixteen bits, two bytes.
// - Cursor address absolute, not start-relative.
// - Vertical sync starts when scanline equals start.
// - Sync ends when low nibble matches end.
// - Write protect blocks indices 0-7, except bit 4.
// - Refresh count five, three, or one override.
// - Interrupt disable keeps interrupt pin inactive.
// - Clear bit low clears pending and pin.
// - Indexed data port, mono relocates to 3Bx.
// - Sync start extended to ten bits by overflow.
// - Cell height field is height minus one.
package crs_pkg;

  // ==========================================================================
  // Port addresses
  localparam logic [15:0] CRS_COLOR_BASE = 16'h03d0;
  localparam logic [15:0] CRS_MONO_BASE  = 16'h03b0;
  localparam logic [15:0] CRS_INDEX_OFS  = 16'h0004;
  localparam logic [15:0] CRS_DATA_OFS   = 16'h0005;

  // ==========================================================================
  // Register indices
  localparam logic [7:0] CRS_IDX_OVERFLOW   = 8'h07;
  localparam logic [7:0] CRS_IDX_CELL       = 8'h09;
  localparam logic [7:0] CRS_IDX_CUR_START  = 8'h0a;
  localparam logic [7:0] CRS_IDX_CUR_END    = 8'h0b;
  localparam logic [7:0] CRS_IDX_START_HI   = 8'h0c;
  localparam logic [7:0] CRS_IDX_START_LO   = 8'h0d;
  localparam logic [7:0] CRS_IDX_CUR_HI     = 8'h0e;
  localparam logic [7:0] CRS_IDX_CUR_LO     = 8'h0f;
  localparam logic [7:0] CRS_IDX_VS_START   = 8'h10;
  localparam logic [7:0] CRS_IDX_VS_END     = 8'h11;
  localparam logic [7:0] CRS_IDX_PROT_LAST  = 8'h07;

  // ==========================================================================
  // Field positions
  localparam int CRS_OVF_VS8      = 2;
  localparam int CRS_OVF_LC8      = 4;
  localparam int CRS_OVF_VS9      = 7;
  localparam int CRS_CS_DISABLE   = 5;
  localparam int CRS_VE_CLEAR     = 4;
  localparam int CRS_VE_DISABLE   = 5;
  localparam int CRS_VE_REFRESH   = 6;
  localparam int CRS_VE_PROTECT   = 7;

  // ==========================================================================
  // Write masks for reserved bits
  localparam logic [7:0] CRS_CUR_START_MASK = 8'h3f;
  localparam logic [7:0] CRS_CUR_END_MASK   = 8'h7f;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] CRS_REG_RESET   = 8'h00;
  localparam logic [2:0] CRS_REFRESH_HI  = 3'h5;
  localparam logic [2:0] CRS_REFRESH_LO  = 3'h3;
  localparam logic [2:0] CRS_REFRESH_ONE = 3'h1;
  localparam int         CRS_SKEW_MAX    = 3;

endpackage : crs_pkg

/* logic/crs_cursor_skew.sv */
// Delay line for the cursor address match, stepped by the character clock enable.
// Assumes the match input is valid in each cycle that the enable is high.
`timescale 1ns/1ps

module crs_cursor_skew
  import crs_pkg::*;
#(
  parameter int DEPTH = CRS_SKEW_MAX
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // Stepping
  input  wire logic       step_i,
  input  wire logic [1:0] skew_i,
  input  wire logic       match_i,
  // Result
  output logic            match_o
);

  initial begin
    if (DEPTH != 3) begin
      $error("crs_cursor_skew: DEPTH must be 3 to serve a two-bit skew.");
    end
  end

  logic [DEPTH:0] tap;
  logic [DEPTH:1] stage_reg;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_reg <= '0;
    end else if (step_i) begin
      stage_reg <= tap[DEPTH-1:0];
    end
  end

  assign tap = {stage_reg, match_i};
  assign match_o = tap[skew_i];

endmodule // crs_cursor_skew

/* testbench/crs_top_sva.sv */
// Port checker for the cursor, screen start and vertical sync block.
// Assumes it is bound into crs_top and sees that module's ports only.
`timescale 1ns/1ps

module crs_top_sva
  import crs_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        io_rd_i,
  input wire logic        mono_mode_i,
  input wire logic [2:0]  start_addr_ext_i,
  input wire logic        start_addr_top_ext_i,
  input wire logic        refresh_one_i,
  input wire logic        char_clk_en_i,
  input wire logic        line_start_i,
  input wire logic [7:0]  io_rdata_o,
  input wire logic        io_rdata_oe_o,
  input wire logic [19:0] start_addr_o,
  input wire logic        cursor_o,
  input wire logic        vsync_o,
  input wire logic [2:0]  refresh_cycles_o,
  input wire logic        irq_pending_o,
  input wire logic        irq_out_n_o
);
  // ==========================================
  // Helper logic
  logic [15:0] dport;
  logic [4:0]  vs_lines;
  assign dport = (mono_mode_i ? CRS_MONO_BASE : CRS_COLOR_BASE) + CRS_DATA_OFS;
  // Counts scanline starts seen while sync is high.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) vs_lines <= 5'h00;
    else if (!vsync_o) vs_lines <= 5'h00;
    else if (line_start_i && vs_lines != 5'h1f) vs_lines <= vs_lines + 5'h01;
  end
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // Assertions
  property p_oe_cause;
    io_rdata_oe_o |-> $past(io_rd_i) && $past(io_addr_i) == $past(dport);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("read strobe without data read");
  property p_rdata_hold;
    $past(nrst_i) && !io_rdata_oe_o |-> $stable(io_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_start_ext;
    $past(nrst_i) |-> start_addr_o[19:16] == $past({start_addr_top_ext_i, start_addr_ext_i});
  endproperty
  a_start_ext: assert property (p_start_ext) else $error("start top bits wrong");
  property p_refresh_one;
    $past(nrst_i) && $past(refresh_one_i) |-> refresh_cycles_o == CRS_REFRESH_ONE;
  endproperty
  a_refresh_one: assert property (p_refresh_one) else $error("override ignored");
  property p_refresh_norm;
    $past(nrst_i) && !$past(refresh_one_i) |-> refresh_cycles_o inside {3'h3, 3'h5};
  endproperty
  a_refresh_norm: assert property (p_refresh_norm) else $error("refresh count bad");
  property p_vs_line;
    $past(nrst_i) && !$past(line_start_i) |-> $stable(vsync_o);
  endproperty
  a_vs_line: assert property (p_vs_line) else $error("sync moved off line start");
  property p_vs_width;
    vs_lines <= 5'h10;
  endproperty
  a_vs_width: assert property (p_vs_width) else $error("sync too long");
  property p_irq_pin;
    !irq_out_n_o |-> irq_pending_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("pin active without pending");
  property p_irq_set;
    $past(nrst_i) && $rose(irq_pending_o) |-> $rose(vsync_o);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("pending set off sync start");
  property p_cur_step;
    $past(nrst_i) && !$past(char_clk_en_i) |-> $stable(cursor_o);
  endproperty
  a_cur_step: assert property (p_cur_step) else $error("cursor moved without clock");
endmodule // crs_top_sva

bind crs_top crs_top_sva u_sva (.ref_clk_i, .nrst_i, .io_addr_i, .io_rd_i, .mono_mode_i,
  .start_addr_ext_i, .start_addr_top_ext_i, .refresh_one_i, .char_clk_en_i, .line_start_i,
  .io_rdata_o, .io_rdata_oe_o, .start_addr_o, .cursor_o, .vsync_o, .refresh_cycles_o,
  .irq_pending_o, .irq_out_n_o);

/* testbench/crs_monitor_model.sv */
// Monitor and interrupt input model: measures sync width and counts interrupts.
// Assumes one clock shared with the block under test.
`timescale 1ns/1ps

module crs_monitor_model (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // Sync and interrupt
  input  wire logic line_start_i,
  input  wire logic vsync_i,
  input  wire logic irq_n_i,
  // Measurements
  output logic [4:0] width_o,
  output logic [3:0] irq_cnt_o
);
  logic [4:0] cnt;
  logic       irq_n_q;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt       <= 5'h00;
      width_o   <= 5'h00;
      irq_cnt_o <= 4'h0;
      irq_n_q   <= 1'b1;
    end else begin
      irq_n_q <= irq_n_i;
      if (irq_n_q && !irq_n_i) irq_cnt_o <= irq_cnt_o + 4'h1;
      if (vsync_i && line_start_i) cnt <= cnt + 5'h01;
      else if (!vsync_i && cnt != 5'h00) begin
        width_o <= cnt;
        cnt     <= 5'h00;
      end
    end
  end
endmodule // crs_monitor_model

/* testbench/crs_top_tb_top.sv */
// Self-checking bench for crs_top, driving its indexed I/O port and CRT counters.
// Assumes the checker is bound in and the monitor model watches sync.
`timescale 1ns/1ps

module crs_top_tb_top;
  import crs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, iwr = 1'b0, ird = 1'b0, mono = 1'b0, top = 1'b0;
  logic rone = 1'b0, cce = 1'b0, ls = 1'b0;
  logic [15:0] addr = 16'h0, base = CRS_COLOR_BASE, fa = 16'h0;
  logic [7:0]  wdata = 8'h0, rdata;
  logic [2:0]  sext = 3'h0, rc;
  logic [9:0]  sl = 10'h0;
  logic [4:0]  rs = 5'h0, ch, width;
  logic [19:0] sa;
  logic [3:0]  irq_cnt;
  logic        oe, cur, vs, prot, pend, irq_n;
  int          n_mismatch = 0, cmp_count = 0;

  always #12.5 clk = ~clk;

  crs_top i_dut (.ref_clk_i(clk), .nrst_i(rst_n), .io_addr_i(addr), .io_wr_i(iwr),
    .io_rd_i(ird), .io_wdata_i(wdata), .io_rdata_o(rdata), .io_rdata_oe_o(oe),
    .mono_mode_i(mono), .start_addr_ext_i(sext), .start_addr_top_ext_i(top),
    .refresh_one_i(rone), .char_clk_en_i(cce), .line_start_i(ls), .scanline_i(sl),
    .row_scan_i(rs), .fetch_addr_i(fa), .start_addr_o(sa), .cell_height_o(ch),
    .cursor_o(cur), .vsync_o(vs), .refresh_cycles_o(rc), .timing_protect_o(prot),
    .irq_pending_o(pend), .irq_out_n_o(irq_n));
  crs_monitor_model i_mon (.ref_clk_i(clk), .nrst_i(rst_n), .line_start_i(ls),
    .vsync_i(vs), .irq_n_i(irq_n), .width_o(width), .irq_cnt_o(irq_cnt));

  // ==========================================
  // Access tasks
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idx(input logic [7:0] i);
    @(posedge clk);
    iwr   <= 1'b1;
    addr  <= base + CRS_INDEX_OFS;
    wdata <= i;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    idx(i);
    @(posedge clk);
    addr  <= base + CRS_DATA_OFS;
    wdata <= d;
    @(posedge clk);
    iwr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic hit, input logic [7:0] e);
    idx(i);
    @(posedge clk);
    iwr  <= 1'b0;
    ird  <= 1'b1;
    addr <= base + CRS_DATA_OFS;
    @(posedge clk);
    ird <= 1'b0;
    #1;
    chk(20'(oe), 20'(hit));
    if (hit) chk(20'(rdata), 20'(e));
  endtask
  task automatic line(input logic [9:0] n);
    @(posedge clk);
    ls <= 1'b1;
    sl <= n;
    @(posedge clk);
    ls <= 1'b0;
    #1;
  endtask
  task automatic frame(input logic en);
    for (int n = 'h11e; n < 'h128; n++) begin
      line(10'(n));
      chk(20'(vs), 20'(n >= 'h120 && n < 'h125));
      chk(20'(pend), 20'(en && n >= 'h120));
      chk(20'(irq_n), 20'(!(en && n >= 'h120)));
    end
    chk(20'(width), 20'h00005);
  endtask
  task automatic cursor(input logic [1:0] s, input logic [4:0] r, input int e);
    int pos;
    pos = -1;
    wr(CRS_IDX_CUR_END, {1'b0, s, 5'h1f});
    rs  <= r;
    cce <= 1'b1;
    fa  <= 16'h1234;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      fa <= 16'h0000;
      #1;
      if (cur === 1'b1 && pos < 0) pos = i;
    end
    @(posedge clk);
    cce <= 1'b0;
    chk(20'(pos), 20'(e));
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(20'(rc), 20'(CRS_REFRESH_LO));
    chk(20'(irq_n), 20'h00001);
    for (int i = 'h0a; i <= 'h11; i++) rd(8'(i), 1'b1, CRS_REG_RESET);
    done("reset");
    for (int i = 'h0a; i <= 'h10; i++) begin
      wr(8'(i), 8'hff);
      rd(8'(i), 1'b1, i == 'h0a ? CRS_CUR_START_MASK : i == 'h0b ? CRS_CUR_END_MASK : 8'hff);
    end
    rd(8'h12, 1'b0, 8'h00);
    done("regs");
    wr(CRS_IDX_START_HI, 8'h12);
    wr(CRS_IDX_START_LO, 8'h34);
    sext <= 3'h5;
    top  <= 1'b1;
    @(posedge clk);
    #1;
    chk(sa, 20'hd1234);
    done("start");
    wr(CRS_IDX_CUR_HI, 8'h12);
    wr(CRS_IDX_CUR_LO, 8'h34);
    wr(CRS_IDX_CELL, 8'h04);
    wr(CRS_IDX_CUR_START, 8'h02);
    chk(20'(ch), 20'h00004);
    for (int s = 0; s < 4; s++) cursor(2'(s), 5'h03, s);
    wr(CRS_IDX_START_HI, 8'h56);
    for (int r = 0; r < 7; r++) cursor(2'h0, 5'(r), (r >= 2 && r <= 4) ? 0 : -1);
    done("cursor");
    for (int i = 0; i < 4; i++) begin
      wr(CRS_IDX_VS_END, {1'b0, i[0], 6'h00});
      rone <= i[1];
      @(posedge clk);
      #1;
      chk(20'(rc), 20'(i[1] ? CRS_REFRESH_ONE : i[0] ? CRS_REFRESH_HI : CRS_REFRESH_LO));
    end
    rone <= 1'b0;
    done("refresh");
    wr(CRS_IDX_OVERFLOW, 8'h04);
    wr(CRS_IDX_VS_END, 8'h80);
    @(posedge clk);
    #1;
    chk(20'(prot), 20'h00001);
    wr(CRS_IDX_OVERFLOW, 8'hff);
    rd(CRS_IDX_OVERFLOW, 1'b1, 8'h14);
    done("protect");
    wr(CRS_IDX_VS_START, 8'h20);
    wr(CRS_IDX_VS_END, {4'h1, 4'(10'h120 + 10'h005)});
    frame(1'b1);
    wr(CRS_IDX_VS_END, 8'h05);
    @(posedge clk);
    #1;
    chk(20'(pend), 20'h00000);
    chk(20'(irq_n), 20'h00001);
    wr(CRS_IDX_VS_END, 8'h35);
    frame(1'b0);
    chk(20'(irq_cnt), 20'h00001);
    done("vsync");
    mono <= 1'b1;
    rd(CRS_IDX_START_LO, 1'b0, 8'h00);
    base = CRS_MONO_BASE;
    rd(CRS_IDX_START_LO, 1'b1, 8'h34);
    done("mono");
    end_of_test();
  end

  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
endmodule // crs_top_tb_top
